// ---- logic/rgbd_dimmer.sv ----
`timescale 1ns/1ps
`default_nettype none
module rgbd_dimmer #(
   parameter longint IDLE_CYCLES = rgbd_pkg::IDLE_CYCLES
) (
   input  wire logic                       clock,
   input  wire logic                       rst,
   input  wire logic                       reg_write,
   input  wire logic                       reg_read,
   input  wire logic [7:0]                 reg_addr,
   input  wire logic [7:0]                 reg_wdata,
   input  wire logic                       bus_command,
   output logic      [7:0]                 reg_rdata,
   output logic      [rgbd_pkg::NUM_CH-1:0] led_out,
   output logic                            power_down
);
   localparam int NC = rgbd_pkg::NUM_CH;
   localparam int NM = rgbd_pkg::NUM_MOD;

   logic [7:0] config0;
   logic [7:0] config1;
   logic [7:0] group_sel;
   logic [7:0] group_brt;
   logic [7:0] group_col [rgbd_pkg::CH_PER_MOD];
   logic [7:0] mod_brt   [NM];
   logic [7:0] ch_col    [NC];

   logic [rgbd_pkg::PWM_CNT_W-1:0]  pwm_count;
   logic [rgbd_pkg::IDLE_CNT_W-1:0] idle_count;
   rgbd_pkg::rgbd_state_e           state;
   rgbd_pkg::rgbd_state_e           next_state;

   logic [NC-1:0] own_pwm;
   logic [NC-1:0] next_led_out;
   logic [2:0]    group_pwm;
   logic [7:0]    next_rdata;

   // decode
   wire        log_curve  = config1[rgbd_pkg::FLD_LOG_CURVE];
   wire        idle_allow = config1[rgbd_pkg::FLD_IDLE_ALLOW];
   wire        wr_cfg0    = reg_write && (reg_addr == rgbd_pkg::OFS_CONFIG0);
   wire        wr_cfg1    = reg_write && (reg_addr == rgbd_pkg::OFS_CONFIG1);
   wire        wr_gsel    = reg_write && (reg_addr == rgbd_pkg::OFS_GROUP_SEL);
   wire        wr_gbrt    = reg_write && (reg_addr == rgbd_pkg::OFS_GROUP_BRT);
   wire [7:0]  gcol_idx   = reg_addr - rgbd_pkg::OFS_GROUP_COL0;
   wire [7:0]  mbrt_idx   = reg_addr - rgbd_pkg::OFS_MOD_BRT0;
   wire [7:0]  ccol_idx   = reg_addr - rgbd_pkg::OFS_CH_COL0;
   wire        in_gcol    = (reg_addr >= rgbd_pkg::OFS_GROUP_COL0) && (gcol_idx < 8'(rgbd_pkg::CH_PER_MOD));
   wire        in_mbrt    = (reg_addr >= rgbd_pkg::OFS_MOD_BRT0) && (mbrt_idx < 8'(NM));
   wire        in_ccol    = (reg_addr >= rgbd_pkg::OFS_CH_COL0) && (ccol_idx < 8'(NC));
   wire        all_off    = (led_out == '0);
   wire        idle_over  = 64'(idle_count) >= 64'(IDLE_CYCLES);
   wire        in_save    = (state == rgbd_pkg::ST_SAVE);

   // config and group registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         config0   <= rgbd_pkg::RST_CONFIG0;
         config1   <= rgbd_pkg::RST_CONFIG1;
         group_sel <= rgbd_pkg::RST_GROUP_SEL;
         group_brt <= rgbd_pkg::RST_BRT;
      end else begin
         if (wr_cfg0) config0 <= reg_wdata;
         if (wr_cfg1) config1 <= reg_wdata;
         if (wr_gsel) group_sel <= reg_wdata;
         if (wr_gbrt) group_brt <= reg_wdata;
      end
   end

   genvar g;
   generate
      for (g = 0; g < rgbd_pkg::CH_PER_MOD; g++) begin : g_group
         always_ff @(posedge clock or posedge rst) begin
            if (rst) group_col[g] <= rgbd_pkg::RST_COL;
            else if (reg_write && in_gcol && gcol_idx == 8'(g)) group_col[g] <= reg_wdata;
         end
         // separate lane set for the group path, same structure as channels
         rgbd_pwm_lane u_group_lane (
            .color_level (group_col[g]),
            .brightness  (group_brt),
            .log_curve   (log_curve),
            .pwm_count   (pwm_count),
            .pwm_on      (group_pwm[g])
         );
      end
      for (g = 0; g < NM; g++) begin : g_mod
         always_ff @(posedge clock or posedge rst) begin
            if (rst) mod_brt[g] <= rgbd_pkg::RST_BRT;
            else if (reg_write && in_mbrt && mbrt_idx == 8'(g)) mod_brt[g] <= reg_wdata;
         end
      end
      for (g = 0; g < NC; g++) begin : g_ch
         always_ff @(posedge clock or posedge rst) begin
            if (rst) ch_col[g] <= rgbd_pkg::RST_COL;
            else if (reg_write && in_ccol && ccol_idx == 8'(g)) ch_col[g] <= reg_wdata;
         end
         rgbd_pwm_lane u_lane (
            .color_level (ch_col[g]),
            .brightness  (mod_brt[g / rgbd_pkg::CH_PER_MOD]),
            .log_curve   (log_curve),
            .pwm_count   (pwm_count),
            .pwm_on      (own_pwm[g])
         );
         // group select overrides the module's own registers entirely
         assign next_led_out[g] = group_sel[g / rgbd_pkg::CH_PER_MOD]
                                  ? group_pwm[g % rgbd_pkg::CH_PER_MOD]
                                  : own_pwm[g];
      end
   endgenerate

   // free-running pwm period counter
   always_ff @(posedge clock or posedge rst) begin
      if (rst) pwm_count <= '0;
      else pwm_count <= pwm_count + 1'b1;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) led_out <= '0;
      else led_out <= next_led_out;
   end

   // idle timer: saturates so a long dark period cannot wrap back to zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) idle_count <= '0;
      else if (!all_off || bus_command) idle_count <= '0;
      else if (!idle_over) idle_count <= idle_count + 1'b1;
   end

   always_comb begin
      next_state = state;
      case (state)
         rgbd_pkg::ST_NORMAL: begin
            if (idle_allow && all_off && idle_over && !bus_command) next_state = rgbd_pkg::ST_SAVE;
         end
         rgbd_pkg::ST_SAVE: begin
            // bus detection stays clocked so a command can wake the core
            if (bus_command) next_state = rgbd_pkg::ST_NORMAL;
         end
         default: next_state = rgbd_pkg::ST_NORMAL;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state      <= rgbd_pkg::ST_NORMAL;
         power_down <= 1'b0;
      end else begin
         state      <= next_state;
         power_down <= (next_state == rgbd_pkg::ST_SAVE);
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = 8'h00;
      if (reg_addr == rgbd_pkg::OFS_CONFIG0) next_rdata = config0;
      else if (reg_addr == rgbd_pkg::OFS_CONFIG1) next_rdata = config1;
      else if (reg_addr == rgbd_pkg::OFS_GROUP_SEL) next_rdata = group_sel;
      else if (reg_addr == rgbd_pkg::OFS_GROUP_BRT) next_rdata = group_brt;
      else if (in_gcol) next_rdata = group_col[gcol_idx[1:0]];
      else if (in_mbrt) next_rdata = mod_brt[mbrt_idx[2:0]];
      else if (in_ccol) next_rdata = ch_col[ccol_idx[4:0]];
      else if (reg_addr == rgbd_pkg::OFS_STATUS) next_rdata = {7'h00, in_save};
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) reg_rdata <= 8'h00;
      else if (reg_read) reg_rdata <= next_rdata;
   end
endmodule : rgbd_dimmer
`default_nettype wire

// ---- logic/rgbd_pkg.sv ----
`default_nettype none
package rgbd_pkg;
   // geometry
   localparam int NUM_CH     = 24;
   localparam int NUM_MOD    = 8;
   localparam int CH_PER_MOD = 3;

   // register offsets (byte addresses on the register port)
   localparam logic [7:0] OFS_CONFIG0     = 8'h00;
   localparam logic [7:0] OFS_CONFIG1     = 8'h01;
   localparam logic [7:0] OFS_GROUP_SEL   = 8'h02;
   localparam logic [7:0] OFS_GROUP_BRT   = 8'h03;
   localparam logic [7:0] OFS_GROUP_COL0  = 8'h04;
   localparam logic [7:0] OFS_MOD_BRT0    = 8'h07;
   localparam logic [7:0] OFS_CH_COL0     = 8'h0F;
   localparam logic [7:0] OFS_STATUS      = 8'h27;

   // field positions in config1
   localparam int FLD_LOG_CURVE  = 5;
   localparam int FLD_IDLE_ALLOW = 4;
   // field position in status
   localparam int FLD_SAVE_STATE = 0;

   // reset values
   localparam logic [7:0] RST_CONFIG0   = 8'h00;
   localparam logic [7:0] RST_CONFIG1   = 8'h3C;
   localparam logic [7:0] RST_GROUP_SEL = 8'h00;
   localparam logic [7:0] RST_BRT       = 8'hFF;
   localparam logic [7:0] RST_COL       = 8'h00;

   // timing
   localparam longint CLK_PERIOD_PS = 20000;
   localparam longint IDLE_TIME_MS  = 30;
   // idle time in clock cycles: the rounded-down count, with no cycle added
   localparam longint IDLE_CYCLES   = (IDLE_TIME_MS * 64'd1000000000) / CLK_PERIOD_PS;
   localparam int     IDLE_CNT_W    = 22;
   localparam int     PWM_CNT_W     = 16;

   typedef enum logic [0:0] {
      ST_NORMAL = 1'b0,
      ST_SAVE   = 1'b1
   } rgbd_state_e;
endpackage : rgbd_pkg
`default_nettype wire

// ---- logic/rgbd_pwm_lane.sv ----
`timescale 1ns/1ps
`default_nettype none
// one colour/brightness pwm lane; shared by own channels and the group path
module rgbd_pwm_lane (
   input  wire logic [7:0]                      color_level,
   input  wire logic [7:0]                      brightness,
   input  wire logic                            log_curve,
   input  wire logic [rgbd_pkg::PWM_CNT_W-1:0]  pwm_count,
   output logic                                 pwm_on
);
   logic [12:0] exp_shift;
   logic [7:0]  log_scaled;
   logic [7:0]  scaled;
   logic [15:0] duty;

   // piecewise exponential: 3-bit exponent, 5-bit mantissa, 0 stays fully dark
   assign exp_shift  = 13'({8'h20 + {3'h0, brightness[4:0]}}) << brightness[7:5];
   assign log_scaled = (brightness == 8'h00) ? 8'h00 : exp_shift[12:5];
   assign scaled     = log_curve ? log_scaled : brightness;
   assign duty       = color_level * scaled;
   assign pwm_on     = pwm_count < duty;
endmodule : rgbd_pwm_lane
`default_nettype wire

// ---- verification/rgbd_dimmer_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module rgbd_dimmer_properties #(
   parameter longint IDLE_CYCLES = 50
) (
   input wire logic                        clock,
   input wire logic                        rst,
   input wire logic                        reg_write,
   input wire logic                        reg_read,
   input wire logic [7:0]                  reg_addr,
   input wire logic [7:0]                  reg_wdata,
   input wire logic                        bus_command,
   input wire logic [7:0]                  reg_rdata,
   input wire logic [rgbd_pkg::NUM_CH-1:0] led_out,
   input wire logic                        power_down
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // run of dark, command-free cycles, counted as the design's idle timer sees them
   longint dark;
   always_ff @(posedge clock or posedge rst)
      if (rst) dark <= 0;
      else dark <= (led_out == 0 && !bus_command) ? dark + 1 : 0;
   a_entry_after_idle: assert property ($rose(power_down) |-> dark > IDLE_CYCLES)
      else $error("power-save entered before the idle time");
   a_entry_when_dark: assert property ($rose(power_down) |-> $past(led_out) == 0)
      else $error("power-save entered with an output lit");
   a_command_blocks: assert property (bus_command && !power_down |=> !power_down)
      else $error("power-save entered despite a command");
   a_save_holds: assert property (power_down && !bus_command |=> power_down)
      else $error("power-save left without a command");
   a_wake_on_cmd: assert property (power_down && bus_command |=> !power_down)
      else $error("command did not end power-save");
   a_wake_cause: assert property ($fell(power_down) |-> $past(bus_command))
      else $error("power-save ended with no command");
   a_status_bit: assert property (reg_read && reg_addr == rgbd_pkg::OFS_STATUS |=>
      reg_rdata == {7'h00, $past(power_down)}) else $error("status does not show power-save");
   a_unmapped_zero: assert property (reg_read && reg_addr > rgbd_pkg::OFS_STATUS |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   c_entry: cover property ($rose(power_down));
   c_wake: cover property ($fell(power_down));
   c_status: cover property (reg_read && reg_addr == rgbd_pkg::OFS_STATUS);
   c_linear: cover property (reg_write && reg_addr == rgbd_pkg::OFS_CONFIG1 && !reg_wdata[rgbd_pkg::FLD_LOG_CURVE]);
endmodule : rgbd_dimmer_properties
bind rgbd_dimmer rgbd_dimmer_properties #(.IDLE_CYCLES(IDLE_CYCLES)) u_props (.clock(clock), .rst(rst),
   .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .bus_command(bus_command), .reg_rdata(reg_rdata), .led_out(led_out), .power_down(power_down));
`default_nettype wire

// ---- verification/rgbd_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rgbd_host_model (
   input  wire logic       clock,
   input  wire logic [7:0] reg_rdata,
   output var logic        reg_write = 1'b0,
   output var logic        reg_read = 1'b0,
   output var logic [7:0]  reg_addr = 8'h00,
   output var logic [7:0]  reg_wdata = 8'h00,
   output var logic        bus_command = 1'b0
);
   // every access is a command to the device, so it also wakes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_write   <= 1'b1;
      reg_addr    <= a;
      reg_wdata   <= d;
      bus_command <= 1'b1;
      @(negedge clock);
      reg_write   <= 1'b0;
      bus_command <= 1'b0;
      reg_addr    <= ~a;
      reg_wdata   <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      reg_read    <= 1'b1;
      reg_addr    <= a;
      bus_command <= 1'b1;
      @(negedge clock);
      reg_read    <= 1'b0;
      bus_command <= 1'b0;
      reg_addr    <= ~a;
      d = reg_rdata;
   endtask : rd
endmodule : rgbd_host_model
`default_nettype wire

// ---- verification/test_rgb_led_pwm_bank_dimmer.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_rgb_led_pwm_bank_dimmer;
   // long enough that the dark gap of a full-scale channel never trips power-save
   localparam longint IDLE = 2000;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   wire logic   reg_write, reg_read, bus_command;
   wire logic [7:0] reg_addr, reg_wdata;
   logic [7:0]  reg_rdata, v, gs, gb, col [24], mb [8], gc [3];
   logic [23:0] led_out;
   logic        power_down;
   int          fails = 0, tests_run = 0, hi [24], cyc = 0, s0 = 0, e = 0;
   logic [7:0]  ra [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h0E, 8'h0F, 8'h26, 8'h27, 8'h30};
   logic [7:0]  rv [10] = '{8'h3C, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
   initial forever #10 clock = ~clock;
   // mirrors the free-running pwm counter, which restarts from zero at reset
   always @(posedge clock or posedge rst) begin
      if (rst) cyc <= 0;
      else cyc <= cyc + 1;
   end
   rgbd_host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .bus_command(bus_command));
   rgbd_dimmer #(.IDLE_CYCLES(IDLE)) dut (.clock(clock), .rst(rst), .reg_write(reg_write), .reg_read(reg_read),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .bus_command(bus_command), .reg_rdata(reg_rdata),
      .led_out(led_out), .power_down(power_down));
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
         fails++;
      end
   endtask : check
   // lin picks the linear curve; the log curve is the reset setting
   function automatic int duty(input logic [7:0] c, input logic [7:0] b, input logic lin);
      logic [15:0] s;
      s = lin ? {8'h00, b} : (b == 8'h00) ? 16'h0000 : ((16'h0020 + b[4:0]) << b[7:5]) >> 5;
      return c * s;
   endfunction : duty
   // high samples in a window of 8192 cycles that starts at counter value st
   function automatic int win(input int d, input int st);
      return (d <= st) ? 0 : (d >= st + 8192) ? 8192 : d - st;
   endfunction : win
   task automatic conclude;
      if (fails == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude
   task automatic do_reset;
      @(negedge clock) rst = 1'b1;
      repeat (6) @(posedge clock);
      @(negedge clock) rst = 1'b0;
   endtask : do_reset
   initial begin
      repeat (90000) @(posedge clock);
      fails++;
      conclude();
   end
   initial begin
      void'($urandom(32'h0FD5));
      do_reset();
      host.wr(8'h27, 8'hFF);
      host.wr(8'h30, 8'hFF);
      foreach (ra[i]) begin
         host.rd(ra[i], v);
         check("reset value", v, rv[i]);
      end
      foreach (col[i]) begin
         col[i] = (i == 9) ? 8'hFF : 8'($urandom);
         host.wr(8'(8'h0F + i), col[i]);
         host.rd(8'(8'h0F + i), v);
         check("colour", v, col[i]);
      end
      foreach (mb[i]) begin
         mb[i] = (i == 2) ? 8'h00 : (i == 3) ? 8'hFF : 8'($urandom);
         host.wr(8'(7 + i), mb[i]);
         host.rd(8'(7 + i), v);
         check("brightness", v, mb[i]);
      end
      foreach (gc[i]) begin
         gc[i] = 8'($urandom);
         host.wr(8'(4 + i), gc[i]);
      end
      gb = 8'($urandom);
      gs = 8'($urandom) & 8'hF7;
      host.wr(8'h03, gb);
      host.wr(8'h02, gs);
      repeat (4) @(negedge clock);
      repeat (65536) begin
         @(negedge clock);
         foreach (hi[c]) hi[c] += led_out[c];
      end
      foreach (hi[c]) begin
         e = gs[c/3] ? duty(gc[c%3], gb, 1'b0) : duty(col[c], mb[c/3], 1'b0);
         check("duty", hi[c], e);
      end
      do_reset();
      repeat (IDLE + 100) @(negedge clock);
      check("save entry", power_down, 1'b1);
      host.rd(8'h00, v);
      check("wake", power_down, 1'b0);
      host.wr(8'h01, 8'h2C);
      repeat (IDLE + 100) @(negedge clock);
      check("save disallowed", power_down, 1'b0);
      host.wr(8'h01, 8'h3C);
      repeat (IDLE + 100) @(negedge clock);
      check("save allowed", power_down, 1'b1);
      host.rd(8'h27, v);
      check("status in save", v, 8'h01);
      check("status wake", power_down, 1'b0);
      // linear curve: short window from just after reset, so the counter phase is known
      do_reset();
      gb = 8'($urandom) & 8'h1F;
      host.wr(8'h01, 8'h1C);
      host.wr(8'h07, gb);
      foreach (gc[i]) begin
         gc[i] = (i == 0) ? 8'hFF : 8'($urandom);
         host.wr(8'(8'h0F + i), gc[i]);
      end
      @(negedge clock);
      s0 = cyc - 1;
      foreach (hi[c]) hi[c] = 0;
      repeat (8192) begin
         foreach (hi[c]) hi[c] += led_out[c];
         @(negedge clock);
      end
      foreach (hi[c]) begin
         e = (c < 3) ? win(duty(gc[c], gb, 1'b1), s0) : 0;
         check("linear duty", hi[c], e);
      end
      conclude();
   end
endmodule : test_rgb_led_pwm_bank_dimmer
`default_nettype wire
